// ### src/iec_cmd_exec.sv
// Interrupt and event command executor for a stepper module command interpreter.
// Assumes decoded command words, context and motion events all arrive on core_clk_i.
`default_nettype none
`include "iec_map.svh"

// Summary of operation
// RL1 - Opcode 26 disables the typed interrupt source
// RL2 - Disable with number 255 clears global enable
// RL3 - Direct mode replies status 100 for these
// RL4 - Opcode 37 stores handler address for interrupt
// RL5 - Redefining a vector overwrites the old one
// RL6 - Vector and return used only in programs; code also runs them in direct mode, reply 100
// RL7 - Opcode 38 restores saved context, resumes execution
// RL8 - Handlers end with return, no fall-through
// RL9 - Opcodes 64..71 are user functions, reply 100
// RL10 - Opcode 138 gives immediate and deferred replies
// RL11 - Value field is motor mask, bit 0
// RL12 - Host sets value field to 1
// RL13 - Type 0 next move only, 1 every move
// RL14 - Host should prefer persistent type 1
// RL15 - Position request accepted only in direct mode
// RL16 - Deferred reply: status 128, command 138, mask
// RL17 - Opcode 25 enables source; 255 enables globally
// RL18 - Taking interrupt saves context, jumps to vector
// RL19 - Dispatch needs source and global enable
module iec_cmd_exec (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Command in
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_direct_i,
   input wire logic [7:0] cmd_op_i,
   input wire logic [7:0] cmd_type_i,
   input wire logic [7:0] cmd_motor_i,
   input wire logic [31:0] cmd_value_i,
   // Reply out
   output logic rep_valid_o,
   input wire logic rep_ready_i,
   output logic [7:0] rep_status_o,
   output logic [7:0] rep_cmd_o,
   output logic [31:0] rep_value_o,
   // Interrupt sources and program context
   input wire logic [`IEC_NUM_IRQ-1:0] irq_pulse_i,
   input wire logic [31:0] ctx_acc_i,
   input wire logic [31:0] ctx_x_i,
   input wire logic [7:0] ctx_flags_i,
   input wire logic [15:0] ctx_pc_i,
   output logic jump_o,
   output logic [15:0] jump_addr_o,
   output logic restore_o,
   output logic [31:0] restore_acc_o,
   output logic [31:0] restore_x_o,
   output logic [7:0] restore_flags_o,
   output logic [15:0] restore_pc_o,
   // User function engine
   output logic uf_start_o,
   output logic [2:0] uf_index_o,
   output logic [7:0] uf_type_o,
   output logic [7:0] uf_motor_o,
   output logic [31:0] uf_value_o,
   input wire logic uf_done_i,
   input wire logic [31:0] uf_result_i,
   // Motion events
   input wire logic move_to_position_cmd_i,
   input wire logic pos_reached_i
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic is_user_op(input logic [7:0] op);
      is_user_op = (op >= `IEC_OP_USER_FIRST) && (op <= `IEC_OP_USER_LAST);
   endfunction

   function automatic iec_pkg::iec_irq_idx_t lowest_set(input iec_pkg::iec_irq_vec_t v);
      lowest_set = '0;
      for (int i = `IEC_NUM_IRQ - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest_set = iec_pkg::iec_irq_idx_t'(i);
         end
      end
   endfunction

   function automatic logic is_source(input logic [7:0] num);
      is_source = (num < 8'(`IEC_NUM_IRQ));
   endfunction

   iec_pkg::iec_state_e state_reg;
   iec_pkg::iec_irq_vec_t irq_en_reg, pend_reg, vec_def_reg, eligible, take_mask;
   iec_pkg::iec_irq_idx_t take_idx;
   logic glob_en_reg, in_handler_reg, accept, take, uf_direct_reg;
   logic pr_armed_reg, pr_persist_reg, track_reg, def_pend_reg, def_load;
   logic [7:0] pr_mask_reg, trk_mask_reg, def_mask_reg;
   logic [31:0] sav_acc_reg, sav_x_reg;
   logic [7:0] sav_flags_reg;
   logic [15:0] sav_pc_reg;
   logic op_ei, op_di, op_vector_define_cmd, op_irq_return_cmd, op_uf, op_pr;

   iec_vec_if vif ();

   iec_vec_mem u_vec_mem (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .vif(vif.mem)
   );

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Deferred reply goes first so position events are never starved by commands
   assign cmd_ready_o = (state_reg == iec_pkg::ST_IDLE) && !rep_valid_o && !def_pend_reg;
   assign accept = cmd_valid_i && cmd_ready_o;
   assign op_ei = accept && (cmd_op_i == `IEC_OP_IRQ_ENABLE);
   assign op_di = accept && (cmd_op_i == `IEC_OP_IRQ_DISABLE);
   assign op_vector_define_cmd = accept && (cmd_op_i == `IEC_OP_VECTOR_DEFINE);
   assign op_irq_return_cmd = accept && (cmd_op_i == `IEC_OP_IRQ_RETURN);
   assign op_uf = accept && is_user_op(cmd_op_i);
   assign op_pr = accept && cmd_direct_i && (cmd_op_i == `IEC_OP_POS_REACHED); // RL15

   // ---------------------------------------------------------------
   // Enables and vector table
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         irq_en_reg <= '0;
         glob_en_reg <= 1'b0;
      end else if (op_ei) begin
         if (cmd_type_i == `IEC_IRQ_GLOBAL) begin
            glob_en_reg <= 1'b1; // RL17
         end else if (is_source(cmd_type_i)) begin
            irq_en_reg[cmd_type_i[`IEC_IRQ_IDX_W-1:0]] <= 1'b1; // RL17
         end
      end else if (op_di) begin
         if (cmd_type_i == `IEC_IRQ_GLOBAL) begin
            glob_en_reg <= 1'b0; // RL2
         end else if (is_source(cmd_type_i)) begin
            irq_en_reg[cmd_type_i[`IEC_IRQ_IDX_W-1:0]] <= 1'b0; // RL1
         end
      end
   end

   // Write and lookup never collide: a dispatch is never started in an accept cycle
   assign vif.wr_en = op_vector_define_cmd && is_source(cmd_type_i); // RL4 RL5
   assign vif.wr_idx = cmd_type_i[`IEC_IRQ_IDX_W-1:0];
   assign vif.wr_addr = cmd_value_i[`IEC_ADDR_W-1:0]; // RL4
   assign vif.rd_idx = take_idx;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         vec_def_reg <= '0;
      end else if (vif.wr_en) begin
         vec_def_reg[vif.wr_idx] <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt dispatch
   // ---------------------------------------------------------------
   // Sources without a vector stay pending until one is defined
   assign eligible = pend_reg & irq_en_reg & vec_def_reg;
   assign take = glob_en_reg && (|eligible) && !in_handler_reg
      && (state_reg == iec_pkg::ST_IDLE) && !accept; // RL19
   assign take_idx = lowest_set(eligible);
   assign take_mask = take ? (iec_pkg::iec_irq_vec_t'(1) << take_idx) : '0;

   // A new event in the cycle it is taken stays pending
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~take_mask) | irq_pulse_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= iec_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            iec_pkg::ST_IDLE: begin
               if (op_uf) begin
                  state_reg <= iec_pkg::ST_UF_WAIT;
               end else if (take) begin
                  state_reg <= iec_pkg::ST_VEC_RD;
               end
            end
            iec_pkg::ST_VEC_RD: begin
               state_reg <= iec_pkg::ST_IDLE;
            end
            iec_pkg::ST_UF_WAIT: begin
               if (uf_done_i) begin
                  state_reg <= iec_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= iec_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sav_acc_reg <= '0;
         sav_x_reg <= '0;
         sav_flags_reg <= '0;
         sav_pc_reg <= '0;
         in_handler_reg <= 1'b0;
      end else if (take) begin
         sav_acc_reg <= ctx_acc_i; // RL18
         sav_x_reg <= ctx_x_i;
         sav_flags_reg <= ctx_flags_i;
         sav_pc_reg <= ctx_pc_i;
         in_handler_reg <= 1'b1;
      end else if (op_irq_return_cmd) begin
         in_handler_reg <= 1'b0; // RL7
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         jump_o <= 1'b0;
         jump_addr_o <= '0;
      end else begin
         jump_o <= (state_reg == iec_pkg::ST_VEC_RD); // RL18
         if (state_reg == iec_pkg::ST_VEC_RD) begin
            jump_addr_o <= vif.rd_addr;
         end
      end
   end

   // A return outside a handler still replays the last saved context
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         restore_o <= 1'b0;
         restore_acc_o <= '0;
         restore_x_o <= '0;
         restore_flags_o <= '0;
         restore_pc_o <= '0;
      end else begin
         restore_o <= op_irq_return_cmd; // RL7
         if (op_irq_return_cmd) begin
            restore_acc_o <= sav_acc_reg;
            restore_x_o <= sav_x_reg;
            restore_flags_o <= sav_flags_reg;
            restore_pc_o <= sav_pc_reg;
         end
      end
   end

   // ---------------------------------------------------------------
   // User functions
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         uf_start_o <= 1'b0;
         uf_index_o <= '0;
         uf_type_o <= '0;
         uf_motor_o <= '0;
         uf_value_o <= '0;
         uf_direct_reg <= 1'b0;
      end else begin
         uf_start_o <= op_uf; // RL9
         if (op_uf) begin
            uf_index_o <= cmd_op_i[2:0];
            uf_type_o <= cmd_type_i;
            uf_motor_o <= cmd_motor_i;
            uf_value_o <= cmd_value_i;
            uf_direct_reg <= cmd_direct_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // Position reached event
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pr_armed_reg <= 1'b0;
         pr_persist_reg <= 1'b0;
         pr_mask_reg <= '0;
      end else if (op_pr) begin
         pr_armed_reg <= 1'b1;
         pr_persist_reg <= cmd_type_i[`IEC_PR_TYPE_PERSIST_BIT]; // RL13
         pr_mask_reg <= cmd_value_i[7:0] & `IEC_MOTOR_MASK; // RL11
      end else if (move_to_position_cmd_i && !pr_persist_reg) begin
         pr_armed_reg <= 1'b0; // RL13
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         track_reg <= 1'b0;
         trk_mask_reg <= '0;
      end else if (move_to_position_cmd_i && pr_armed_reg) begin
         track_reg <= 1'b1;
         trk_mask_reg <= pr_mask_reg;
      end else if (pos_reached_i) begin
         track_reg <= 1'b0;
      end
   end

   // Set wins over the load that clears it
   assign def_load = def_pend_reg && !rep_valid_o && (state_reg == iec_pkg::ST_IDLE);

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         def_pend_reg <= 1'b0;
         def_mask_reg <= '0;
      end else if (pos_reached_i && track_reg) begin
         def_pend_reg <= 1'b1; // RL10
         def_mask_reg <= trk_mask_reg;
      end else if (def_load) begin
         def_pend_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Reply
   // ---------------------------------------------------------------
   // Stored-program commands produce no reply
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rep_valid_o <= 1'b0;
         rep_status_o <= '0;
         rep_cmd_o <= '0;
         rep_value_o <= '0;
      end else if (def_load) begin
         rep_valid_o <= 1'b1;
         rep_status_o <= `IEC_ST_POS_REACHED; // RL16
         rep_cmd_o <= `IEC_OP_POS_REACHED;
         rep_value_o <= {24'h0, def_mask_reg};
      end else if (accept && cmd_direct_i && !op_uf) begin
         rep_valid_o <= 1'b1;
         rep_cmd_o <= cmd_op_i;
         rep_value_o <= op_pr ? {24'h0, cmd_value_i[7:0]} : '0; // RL10
         if (op_ei || op_di || op_vector_define_cmd || op_irq_return_cmd || op_pr) begin
            rep_status_o <= `IEC_ST_OK; // RL3
         end else begin
            rep_status_o <= `IEC_ST_INVALID_CMD;
         end
      end else if ((state_reg == iec_pkg::ST_UF_WAIT) && uf_done_i && uf_direct_reg) begin
         rep_valid_o <= 1'b1;
         rep_status_o <= `IEC_ST_OK; // RL9
         rep_cmd_o <= {5'h08, uf_index_o};
         rep_value_o <= uf_result_i;
      end else if (rep_ready_i) begin
         rep_valid_o <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// ### src/iec_map.svh
// Constants for the interrupt and event command executor: opcodes, status codes, sizes.
// Included by bare name from every file that needs a number.
`ifndef IEC_MAP_SVH
`define IEC_MAP_SVH

// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define IEC_OP_IRQ_ENABLE 8'h19
`define IEC_OP_IRQ_DISABLE 8'h1a
`define IEC_OP_VECTOR_DEFINE 8'h25
`define IEC_OP_IRQ_RETURN 8'h26
`define IEC_OP_USER_FIRST 8'h40
`define IEC_OP_USER_LAST 8'h47
`define IEC_OP_POS_REACHED 8'h8a

// ---------------------------------------------------------------
// Field values and status codes
// ---------------------------------------------------------------
`define IEC_IRQ_GLOBAL 8'hff
`define IEC_PR_TYPE_PERSIST_BIT 0
`define IEC_MOTOR_MASK 8'h01
`define IEC_ST_OK 8'h64
`define IEC_ST_POS_REACHED 8'h80
`define IEC_ST_INVALID_CMD 8'h02

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define IEC_NUM_IRQ 16
`define IEC_IRQ_IDX_W 4
`define IEC_ADDR_W 16

`endif

// ### src/iec_pkg.sv
// Types shared by the interrupt and event command executor.
// Assumes iec_map.svh is on the include path.
`default_nettype none
`include "iec_map.svh"

package iec_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_VEC_RD = 3'h2,
      ST_UF_WAIT = 3'h4
   } iec_state_e;

   typedef logic [`IEC_NUM_IRQ-1:0] iec_irq_vec_t;
   typedef logic [`IEC_IRQ_IDX_W-1:0] iec_irq_idx_t;
   typedef logic [`IEC_ADDR_W-1:0] iec_addr_t;
endpackage

`default_nettype wire

// ### src/iec_vec_if.sv
// Port bundle between the executor and its vector table.
// Assumes a single clock shared by both ends.
`default_nettype none

interface iec_vec_if;
   logic wr_en;
   iec_pkg::iec_irq_idx_t wr_idx;
   iec_pkg::iec_addr_t wr_addr;
   iec_pkg::iec_irq_idx_t rd_idx;
   iec_pkg::iec_addr_t rd_addr;
   modport ctrl (output wr_en, output wr_idx, output wr_addr, output rd_idx, input rd_addr);
   modport mem (input wr_en, input wr_idx, input wr_addr, input rd_idx, output rd_addr);
endinterface

`default_nettype wire

// ### src/iec_vec_mem.sv
// Interrupt vector table: one handler entry address per interrupt number.
// Read data are registered, so a lookup costs one clock.
`default_nettype none
`include "iec_map.svh"

module iec_vec_mem (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Table port
   iec_vec_if.mem vif
);
   iec_pkg::iec_addr_t table_reg [`IEC_NUM_IRQ];

   // Later writes simply replace the entry
   always_ff @(posedge core_clk_i) begin
      if (vif.wr_en) begin
         table_reg[vif.wr_idx] <= vif.wr_addr;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         vif.rd_addr <= '0;
      end else begin
         vif.rd_addr <= table_reg[vif.rd_idx];
      end
   end
endmodule

`default_nettype wire

// ### tb/iec_cmd_exec_sva.sv
// Checker for the interrupt and event command executor.
// Assumes it sees only the top module's ports, on one clock.
`default_nettype none

module iec_cmd_exec_sva (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Command and reply
   input wire logic cmd_valid_i,
   input wire logic cmd_ready_o,
   input wire logic cmd_direct_i,
   input wire logic [7:0] cmd_op_i,
   input wire logic [31:0] cmd_value_i,
   input wire logic [7:0] cmd_type_i,
   input wire logic [7:0] cmd_motor_i,
   input wire logic rep_valid_o,
   input wire logic rep_ready_i,
   input wire logic [7:0] rep_status_o,
   input wire logic [7:0] rep_cmd_o,
   input wire logic [31:0] rep_value_o,
   // Handler and user function side
   input wire logic jump_o,
   input wire logic restore_o,
   input wire logic uf_start_o,
   input wire logic [2:0] uf_index_o,
   input wire logic [7:0] uf_type_o,
   input wire logic [7:0] uf_motor_o,
   input wire logic uf_done_i,
   input wire logic [31:0] uf_result_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic take;
   assign take = cmd_valid_i && cmd_ready_o;

   a_irq_cmd_reply: assert property (take && cmd_direct_i &&
      cmd_op_i inside {8'h19, 8'h1a, 8'h25, 8'h26} |=> rep_valid_o && rep_status_o == 8'h64
      && rep_cmd_o == $past(cmd_op_i) && rep_value_o == 32'h0) else $error("irq cmd reply wrong");
   a_pr_first_reply: assert property (take && cmd_direct_i && cmd_op_i == 8'h8a
      |=> rep_valid_o && rep_status_o == 8'h64 && rep_cmd_o == 8'h8a
      && rep_value_o == {24'h0, $past(cmd_value_i[7:0])}) else $error("event request reply wrong");
   a_pr_stored_ignored: assert property (take && !cmd_direct_i && cmd_op_i == 8'h8a
      |=> !rep_valid_o) else $error("stored event request answered");
   a_uf_launch: assert property (take && cmd_op_i[7:3] == 5'h08
      |=> uf_start_o && uf_index_o == $past(cmd_op_i[2:0])) else $error("user function not started");
   a_uf_fields: assert property (take && cmd_op_i[7:3] == 5'h08
      |=> uf_type_o == $past(cmd_type_i) && uf_motor_o == $past(cmd_motor_i))
      else $error("user function fields wrong");
   a_uf_result: assert property ($rose(rep_valid_o) && rep_cmd_o[7:3] == 5'h08
      |-> rep_status_o == 8'h64 && $past(uf_done_i) && rep_value_o == $past(uf_result_i))
      else $error("user function reply wrong");
   a_deferred_fields: assert property ($rose(rep_valid_o) && rep_status_o == 8'h80
      |-> rep_cmd_o == 8'h8a && rep_value_o[31:1] == 31'h0) else $error("deferred reply wrong");
   a_ret_restore: assert property (take && cmd_op_i == 8'h26 |=> restore_o)
      else $error("return gave no restore");
   a_jump_single: assert property (jump_o |=> !jump_o) else $error("jump pulse too long");
   a_reply_hold: assert property (rep_valid_o && !rep_ready_i |=> rep_valid_o
      && $stable({rep_status_o, rep_cmd_o, rep_value_o})) else $error("reply dropped");
   a_busy_refuse: assert property (rep_valid_o |-> !cmd_ready_o)
      else $error("ready while reply held");
endmodule

bind iec_cmd_exec iec_cmd_exec_sva i_sva (.core_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_ready_o,
   .cmd_direct_i, .cmd_op_i, .cmd_value_i, .cmd_type_i, .cmd_motor_i, .rep_valid_o,
   .rep_ready_i, .rep_status_o, .rep_cmd_o, .rep_value_o, .jump_o, .restore_o, .uf_start_o,
   .uf_index_o, .uf_type_o, .uf_motor_o, .uf_done_i, .uf_result_i);

`default_nettype wire

// ### tb/iec_far_model.sv
// Far-side model: user function engine and motor motion.
// Assumes the bench asks for moves and sets the latency.
`default_nettype none

module iec_far_model (
   // Clock
   input wire logic core_clk_i,
   // User function engine
   input wire logic uf_start_i,
   input wire logic [2:0] uf_index_i,
   input wire logic [31:0] uf_value_i,
   output logic uf_done_o,
   output logic [31:0] uf_result_o,
   // Motion
   input wire logic move_req_i,
   input wire logic [7:0] lag_i,
   output logic move_cmd_o,
   output logic pos_hit_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int uf_cnt = -1;
   int mv_cnt = -1;
   logic [31:0] res = 32'h0;
   initial begin
      uf_done_o = 1'b0;
      uf_result_o = 32'h0;
      move_cmd_o = 1'b0;
      pos_hit_o = 1'b0;
   end
   // Result toggles outside the done pulse so a late sample cannot match
   always @(posedge core_clk_i) begin
      uf_done_o <= 1'b0;
      uf_result_o <= ~uf_result_o;
      move_cmd_o <= move_req_i;
      pos_hit_o <= 1'b0;
      if (uf_start_i) begin
         uf_cnt <= lag_i;
         res <= uf_value_i + {29'h0, uf_index_i};
      end else if (uf_cnt == 0) begin
         uf_done_o <= 1'b1;
         uf_result_o <= res;
         uf_cnt <= -1;
      end else if (uf_cnt > 0) begin
         uf_cnt <= uf_cnt - 1;
      end
      if (move_req_i) begin
         mv_cnt <= lag_i + 1;
      end else if (mv_cnt == 0) begin
         pos_hit_o <= 1'b1;
         mv_cnt <= -1;
      end else if (mv_cnt > 0) begin
         mv_cnt <= mv_cnt - 1;
      end
   end
endmodule

`default_nettype wire

// ### tb/iec_cmd_exec_tb_top.sv
// Self-checking bench for the interrupt and event command executor.
// Assumes the checker binds itself and the far model answers user functions and moves.
`default_nettype none

module iec_cmd_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i, sys_rst_i, cmd_valid_i, cmd_ready_o, cmd_direct_i, rep_valid_o;
   logic rep_ready_i, jump_o, restore_o, uf_start_o, uf_done_i, move_req;
   logic move_to_position_cmd_i, pos_reached_i;
   logic [7:0] cmd_op_i, cmd_type_i, cmd_motor_i, rep_status_o, rep_cmd_o, ctx_flags_i;
   logic [7:0] restore_flags_o, uf_type_o, uf_motor_o, lag;
   logic [31:0] cmd_value_i, rep_value_o, ctx_acc_i, ctx_x_i, restore_acc_o, restore_x_o;
   logic [31:0] uf_value_o, uf_result_i;
   logic [15:0] irq_pulse_i, ctx_pc_i, jump_addr_o, restore_pc_o;
   logic [2:0] uf_index_o;
   integer seed = 72741;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   logic [47:0] rep_q[$];
   logic [15:0] jmp_q[$];
   logic [87:0] ret_q[$];

   iec_cmd_exec i_dut (.*);
   iec_far_model i_far (.core_clk_i, .uf_start_i(uf_start_o), .uf_index_i(uf_index_o),
      .uf_value_i(uf_value_o), .uf_done_o(uf_done_i), .uf_result_o(uf_result_i),
      .move_req_i(move_req), .lag_i(lag), .move_cmd_o(move_to_position_cmd_i),
      .pos_hit_o(pos_reached_i));

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic wrap_up();
      if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [87:0] got, input logic [87:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_rep(input logic [47:0] got, input logic [47:0] exp);
      chk(88'(got), 88'(exp));
   endtask

   task automatic chk_jump(input logic [15:0] got, input logic [15:0] exp);
      chk(88'(got), 88'(exp));
   endtask

   task automatic chk_ret(input logic [87:0] got, input logic [87:0] exp);
      chk(got, exp);
   endtask

   task automatic chk_left(input logic [31:0] got, input logic [31:0] exp);
      chk(88'(got), 88'(exp));
   endtask

   // Queues the expected direct-mode reply, then holds the command until taken
   task automatic send(input logic dir, input logic [7:0] op, ty, input logic [31:0] v);
      if (dir && op[7:3] == 5'h08) rep_q.push_back({8'h64, op, v + op[2:0]});
      else if (dir) rep_q.push_back({op inside {8'h19, 8'h1a, 8'h25, 8'h26, 8'h8a} ? 8'h64
         : 8'h02, op, op == 8'h8a ? {24'h0, v[7:0]} : 32'h0});
      @(posedge core_clk_i);
      cmd_valid_i <= 1'b1;
      cmd_direct_i <= dir;
      cmd_op_i <= op;
      cmd_type_i <= ty;
      cmd_motor_i <= 8'($random(seed));
      cmd_value_i <= v;
      forever begin
         @(negedge core_clk_i);
         if (cmd_ready_o === 1'b1) break;
      end
      @(posedge core_clk_i);
      cmd_valid_i <= 1'b0;
      cmd_value_i <= ~v;
   endtask

   task automatic ret();
      repeat (12) @(posedge core_clk_i);
      ret_q.push_back({ctx_acc_i, ctx_x_i, ctx_flags_i, ctx_pc_i});
      send(1'b0, 8'h26, 8'h0, 32'h0);
   endtask

   task automatic irq(input int n, input logic [15:0] addr, input logic take);
      @(posedge core_clk_i);
      ctx_acc_i <= $random(seed);
      ctx_x_i <= $random(seed);
      ctx_flags_i <= 8'($random(seed));
      ctx_pc_i <= 16'($random(seed));
      irq_pulse_i <= 16'h1 << n;
      @(posedge core_clk_i);
      irq_pulse_i <= 16'h0;
      if (take) jmp_q.push_back(addr);
      if (take) ret();
      else repeat (12) @(posedge core_clk_i);
   endtask

   task automatic move(input logic exp);
      if (exp) rep_q.push_back({8'h80, 8'h8a, 32'h1});
      @(posedge core_clk_i);
      lag <= 8'($random(seed)) & 8'h07;
      move_req <= 1'b1;
      @(posedge core_clk_i);
      move_req <= 1'b0;
      repeat (14) @(posedge core_clk_i);
   endtask

   // ---------------------------------------------------------------
   // Output watcher: oldest note against each result
   // ---------------------------------------------------------------
   always @(posedge core_clk_i) begin
      cycles++;
      rep_ready_i <= 1'($random(seed));
      if (!sys_rst_i && rep_valid_o && rep_ready_i)
         chk_rep({rep_status_o, rep_cmd_o, rep_value_o},
            rep_q.size() ? rep_q.pop_front() : 'x);
      if (!sys_rst_i && jump_o)
         chk_jump(jump_addr_o, jmp_q.size() ? jmp_q.pop_front() : 'x);
      if (!sys_rst_i && restore_o)
         chk_ret({restore_acc_o, restore_x_o, restore_flags_o, restore_pc_o},
            ret_q.size() ? ret_q.pop_front() : 'x);
      if (cycles > 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {sys_rst_i, cmd_valid_i, cmd_direct_i, move_req} = 4'b1000;
      {cmd_op_i, cmd_type_i, cmd_motor_i, cmd_value_i, lag} = '0;
      {irq_pulse_i, ctx_acc_i, ctx_x_i, ctx_flags_i, ctx_pc_i} = '0;
      repeat (8) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      send(1'b1, 8'h19, 8'hff, 32'h0);
      send(1'b1, 8'h19, 8'h03, 32'h0);
      send(1'b0, 8'h25, 8'h03, 32'h1234);
      irq(3, 16'h1234, 1'b1);
      send(1'b0, 8'h25, 8'h03, 32'h0abc);
      irq(3, 16'h0abc, 1'b1);
      send(1'b1, 8'h1a, 8'h03, 32'h0);
      irq(3, 16'h0, 1'b0);
      send(1'b1, 8'h19, 8'h05, 32'h0);
      send(1'b0, 8'h25, 8'h05, 32'h0055);
      send(1'b1, 8'h1a, 8'hff, 32'h0);
      irq(5, 16'h0, 1'b0);
      jmp_q.push_back(16'h0055);
      send(1'b1, 8'h19, 8'hff, 32'h0);
      ret();
      for (int i = 0; i < 8; i++) begin
         lag <= 8'($random(seed)) & 8'h03;
         send(1'b1, 8'h40 + 8'(i), 8'($random(seed)), $random(seed));
      end
      send(1'b1, 8'h7f, 8'h00, 32'h5);
      send(1'b0, 8'h8a, 8'h01, 32'h1);
      move(1'b0);
      send(1'b1, 8'h8a, 8'h00, 32'h1);
      move(1'b1);
      move(1'b0);
      send(1'b1, 8'h8a, 8'h01, 32'h1);
      move(1'b1);
      move(1'b1);
      repeat (20) @(posedge core_clk_i);
      chk_left(rep_q.size() + jmp_q.size() + ret_q.size(), 32'h0);
      wrap_up();
   end
endmodule

`default_nettype wire
